// ### logic/padc_fifo.sv
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/10ps
module padc_fifo
  import padc_pkg::*;
#(
  parameter int unsigned WIDTH = FIFO_WIDTH,  // Word width
  parameter int unsigned DEPTH = FIFO_DEPTH   // Depth in words
) (
  input  wire logic             clk_in,     // System clock
  input  wire logic             arst_n_in,  // Asynchronous reset, active low
  input  wire logic             in_valid_in, // Write side valid
  output logic                  in_ready_out, // Write side ready
  input  wire logic [WIDTH-1:0] in_data_in, // Write data
  output logic                  out_valid_out, // Read side valid
  input  wire logic             out_ready_in, // Read side ready
  output logic      [WIDTH-1:0] out_data_out // Read data
);
  localparam int unsigned AW = $clog2(DEPTH);  // Pointer width

  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [AW:0]      wr_ptr;       // Write pointer with wrap bit
  logic [AW:0]      rd_ptr;       // Read pointer with wrap bit
  logic             push;         // Write accepted
  logic             pop;          // Read accepted

  // ==========================================================================
  // Flags
  // ==========================================================================
  assign in_ready_out  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid_out = (wr_ptr != rd_ptr);
  assign out_data_out  = mem[rd_ptr[AW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // Storage write
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  // Pointer update
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ### logic/padc_top.sv
// Digital output path of the pipelined converter
`timescale 1ns/10ps
// Function
// - Word reaches bus third master cycle after sampling
// - After latency, one new word per clock
// - Output word registered on master clock
// - Output coded as offset binary
// - Twelve bits, MSB highest, LSB bit zero
// - Two non-overlapping phases from master clock
// - Capture at sample phase end, hold after
// - Four stages, four bits each, gain eight
// - Each stage clock opposite previous stage
// - Stage codes delayed to align one sample
// - Redundant correction forms the twelve-bit word
module padc_top
  import padc_pkg::*;
(
  input  wire logic        CLK_SYS_IN,      // Master clock
  input  wire logic        ARST_N_IN,       // Asynchronous reset, active low
  input  wire logic [3:0]  STAGE0_CODE_IN,  // First stage flash code
  input  wire logic [3:0]  STAGE1_CODE_IN,  // Second stage flash code
  input  wire logic [3:0]  STAGE2_CODE_IN,  // Third stage flash code
  input  wire logic [3:0]  STAGE3_CODE_IN,  // Last stage flash code
  output logic             SAMPLE_PHASE_OUT, // Sample phase to the front end
  output logic             HOLD_PHASE_OUT,  // Hold phase to the front end
  output logic             STAGE_ODD_OUT,   // Clock of the odd stages
  output logic [11:0]      OUT_WORD_OUT,    // Offset binary output bus
  output logic             OUT_VALID_OUT,   // Bus holds a settled word
  output logic             STALL_OUT        // Buffer refused a word
);
  // ==========================================================================
  // Declarations
  // ==========================================================================
  padc_phase_type   phase;       // Non-overlapping phase state
  padc_phase_type   next_phase;  // Next phase state
  logic [3:0]       s0_sync1;    // First stage code, first flop
  logic [3:0]       s0_sync2;    // First stage code, second flop
  logic [3:0]       s1_sync1;    // Second stage code, first flop
  logic [3:0]       s1_sync2;    // Second stage code, second flop
  logic [3:0]       s2_sync1;    // Third stage code, first flop
  logic [3:0]       s2_sync2;    // Third stage code, second flop
  logic [3:0]       s3_sync1;    // Last stage code, first flop
  logic [3:0]       s3_sync2;    // Last stage code, second flop
  logic [3:0]       d0_a;        // First stage delay tap
  logic [3:0]       d0_b;        // First stage delay tap
  logic [3:0]       d0_c;        // First stage delay tap
  logic [3:0]       d1_a;        // Second stage delay tap
  logic [3:0]       d1_b;        // Second stage delay tap
  logic [3:0]       d2_a;        // Third stage delay tap
  logic [11:0]      corr_word;   // Corrected word
  logic [15:0]      corr_sum;    // Full corrected sum
  logic             fifo_rdy;    // Buffer ready
  logic             fifo_vld;    // Buffer holds a word
  logic [11:0]      fifo_data;   // Buffer head
  logic [1:0]       lat_cnt;     // Pipeline fill counter
  logic             fill_done;   // Pipeline has filled

  // ==========================================================================
  // Phase generation
  // ==========================================================================
  // Phase walks sample, gap, hold, gap so phases never overlap; one slot per
  // master cycle, so each phase stands one cycle in four
  always_comb begin
    unique case (phase)
      PH_SAMPLE: next_phase = PH_GAP1;
      PH_GAP1:   next_phase = PH_HOLD;
      PH_HOLD:   next_phase = PH_GAP2;
      PH_GAP2:   next_phase = PH_SAMPLE;
    endcase
  end

  // Phase state register
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      phase <= PH_GAP2;
    end else begin
      phase <= next_phase;
    end
  end

  // Phase outputs straight from flops, never both high
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      SAMPLE_PHASE_OUT <= 1'b0;
      HOLD_PHASE_OUT   <= 1'b0;
      STAGE_ODD_OUT    <= 1'b0;
    end else begin
      SAMPLE_PHASE_OUT <= (next_phase == PH_SAMPLE);
      HOLD_PHASE_OUT   <= (next_phase == PH_HOLD);
      STAGE_ODD_OUT    <= (next_phase == PH_HOLD);
    end
  end

  // ==========================================================================
  // Stage code capture
  // ==========================================================================
  // Codes come from the analog core, so two flops each
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      s0_sync1 <= CODE_RESET;
      s0_sync2 <= CODE_RESET;
      s1_sync1 <= CODE_RESET;
      s1_sync2 <= CODE_RESET;
      s2_sync1 <= CODE_RESET;
      s2_sync2 <= CODE_RESET;
      s3_sync1 <= CODE_RESET;
      s3_sync2 <= CODE_RESET;
    end else begin
      s0_sync1 <= STAGE0_CODE_IN;
      s0_sync2 <= s0_sync1;
      s1_sync1 <= STAGE1_CODE_IN;
      s1_sync2 <= s1_sync1;
      s2_sync1 <= STAGE2_CODE_IN;
      s2_sync2 <= s2_sync1;
      s3_sync1 <= STAGE3_CODE_IN;
      s3_sync2 <= s3_sync1;
    end
  end

  // ==========================================================================
  // Alignment delay line
  // ==========================================================================
  // Earlier stages wait longer so all four codes of a sample meet
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      d0_a <= CODE_RESET;
      d0_b <= CODE_RESET;
      d0_c <= CODE_RESET;
      d1_a <= CODE_RESET;
      d1_b <= CODE_RESET;
      d2_a <= CODE_RESET;
    end else begin
      d0_a <= s0_sync2;
      d0_b <= d0_a;
      d0_c <= d0_b;
      d1_a <= s1_sync2;
      d1_b <= d1_a;
      d2_a <= s2_sync2;
    end
  end

  // ==========================================================================
  // Error correction
  // ==========================================================================
  // Each stage overlaps the next by one bit; shift by three and add, the
  // redundant bit absorbs flash errors; last stage code is signed offset
  always_comb begin
    corr_sum = ({12'h000, d0_c} << (STAGE_SHIFT * 3))
             + ({12'h000, d1_b} << (STAGE_SHIFT * 2))
             + ({12'h000, d2_a} << STAGE_SHIFT)
             + {12'h000, s3_sync2}
             - CORR_OFFSET;
    corr_word = padc_clamp(corr_sum);
  end

  // ==========================================================================
  // Output buffer
  // ==========================================================================
  padc_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (CLK_SYS_IN),
    .arst_n_in     (ARST_N_IN),
    .in_valid_in   (fill_done),
    .in_ready_out  (fifo_rdy),
    .in_data_in    (corr_word),
    .out_valid_out (fifo_vld),
    .out_ready_in  (1'b1),
    .out_data_out  (fifo_data)
  );

  // Fill counter marks when the pipeline carries real samples
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      lat_cnt <= LAT_RESET;
    end else if (lat_cnt != LAT_DONE) begin
      lat_cnt <= lat_cnt + LAT_ONE;
    end
  end
  assign fill_done = (lat_cnt == LAT_DONE);

  // ==========================================================================
  // Output latch
  // ==========================================================================
  // One word per master clock, bit eleven on the top line
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      OUT_WORD_OUT  <= WORD_RESET;
      OUT_VALID_OUT <= 1'b0;
      STALL_OUT     <= 1'b0;
    end else begin
      OUT_WORD_OUT  <= fifo_vld ? fifo_data : OUT_WORD_OUT;
      OUT_VALID_OUT <= fifo_vld;
      STALL_OUT     <= fill_done && !fifo_rdy;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence seq_sample;
    SAMPLE_PHASE_OUT;
  endsequence
  sequence seq_hold_after;
    !SAMPLE_PHASE_OUT ##1 HOLD_PHASE_OUT;
  endsequence

  a_phase_no_overlap: assert property (
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    !(SAMPLE_PHASE_OUT && HOLD_PHASE_OUT))
    else $error("phases overlap");

  a_hold_follows_sample: assert property (
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    seq_sample |=> seq_hold_after)
    else $error("hold does not follow sample");

  a_stage_opposite: assert property (
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    SAMPLE_PHASE_OUT |-> ##2 (STAGE_ODD_OUT && !SAMPLE_PHASE_OUT))
    else $error("odd stage clock not opposite");

  a_align_first: assert property (
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    ##3 d0_c == $past(s0_sync2, 3))
    else $error("first stage delay wrong");

  a_align_second: assert property (
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    ##2 d1_b == $past(s1_sync2, 2))
    else $error("second stage delay wrong");

  a_latency_three: assert property (
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    fill_done && $past(fill_done) |=> ##1 OUT_WORD_OUT == $past(corr_word, 2))
    else $error("latency not met");

  a_word_per_clock: assert property (
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    fill_done |-> ##2 OUT_VALID_OUT)
    else $error("word missing");

  a_code_range: assert property (
    @(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
    corr_sum[15] |=> ##1 OUT_WORD_OUT == WORD_RESET)
    else $error("underrange not all zeros");
endmodule

// ### pkg/padc_pkg.sv
// Package of constants for the pipelined converter output path
package padc_pkg;
  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned OUT_WIDTH     = 12;  // Output word width
  localparam int unsigned STAGE_WIDTH   = 4;   // Bits resolved per stage
  localparam int unsigned STAGE_COUNT   = 4;   // Pipeline stages
  localparam int unsigned STAGE_SHIFT   = 3;   // Gain of 8 is a shift of three
  localparam int unsigned FIFO_WIDTH    = 12;  // Buffer word width
  localparam int unsigned FIFO_DEPTH    = 32;  // Buffer depth in words
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned LATENCY_CYC   = 3;   // Master cycles from sample to bus
  localparam int unsigned ALIGN_CYC     = 2;   // Half-cycle count of sample phase
  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [11:0] WORD_RESET    = 12'h000;  // Output word after reset
  localparam logic [3:0]  CODE_RESET    = 4'h0;     // Stage code after reset
  localparam logic [1:0]  PHASE_RESET   = 2'h0;     // Phase divider after reset
  localparam logic [1:0]  FULL_ONE      = 2'h1;     // Divider step
  localparam logic [1:0]  LAT_RESET     = 2'h0;     // Latency counter after reset
  localparam logic [1:0]  LAT_DONE      = 2'h2;     // Counter value once filled
  localparam logic [1:0]  LAT_ONE       = 2'h1;     // Latency counter step
  localparam logic [15:0] ACC_TOP       = 16'h0FFF; // Largest legal code
  localparam logic [15:0] CORR_OFFSET   = 16'h0444; // Redundancy offset taken off the sum

  // Phase states of the non-overlapping clock
  typedef enum logic [1:0] {
    PH_SAMPLE = 2'b00,  // Sample phase high
    PH_GAP1   = 2'b01,  // Both low, end of sample
    PH_HOLD   = 2'b10,  // Hold phase high
    PH_GAP2   = 2'b11   // Both low, end of hold
  } padc_phase_type;

  // Clamp a corrected sum into the output range
  function automatic logic [11:0] padc_clamp(input logic [15:0] sum);
    if (sum[15]) begin
      padc_clamp = WORD_RESET;
    end else if (sum > ACC_TOP) begin
      padc_clamp = ACC_TOP[11:0];
    end else begin
      padc_clamp = sum[11:0];
    end
  endfunction
endpackage

// ### test/padc_capture.sv
// Capture model of the logic that takes the converter's output words
`timescale 1ns/10ps
module padc_capture (
  input  wire logic        clk_in,    // Master clock
  input  wire logic [11:0] word_in,   // Output word bus
  input  wire logic        valid_in,  // Word valid level
  input  wire logic        stall_in   // Buffer refusal flag
);
  // ==========================================================================
  // Logs indexed by master clock count
  // ==========================================================================
  localparam int LOG_DEPTH = 1024; // Clocks the logs can hold
  int          cyc = 0;                // Master clocks seen so far
  logic [11:0] word_log [LOG_DEPTH];   // Word taken at each clock
  logic        valid_log [LOG_DEPTH];  // Valid level at each clock
  logic        stall_log [LOG_DEPTH];  // Refusal flag at each clock

  // Take one word per master clock, so the bench can count latency in cycles
  always @(posedge clk_in) begin
    if (cyc < LOG_DEPTH) begin
      word_log[cyc]  <= word_in;
      valid_log[cyc] <= valid_in;
      stall_log[cyc] <= stall_in;
    end
    cyc <= cyc + 1;
  end
endmodule

// ### test/testbench.sv
// Self-checking bench for the converter output path
`timescale 1ns/10ps
module testbench;
  import padc_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        clk_sys = 1'b0;  // Master clock
  logic        arst_n  = 1'b0;  // Reset, active low
  logic [3:0]  code [4];        // Stage codes from the analog core
  logic        smp_ph, hld_ph, odd_ph; // Phase outputs
  logic [11:0] word;            // Output bus
  logic        valid, stall;    // Bus flags
  logic [3:0]  smp [64][4];     // Sample table, one code per stage
  int          mismatches = 0;  // Failed comparisons
  int          cmp_count  = 0;  // Comparisons made
  int          lat_a, lat_b;    // Measured latencies of two runs
  // Last stage code edge plus the latency, plus one as the log keeps the pre-edge word
  localparam int LAT_EXP = STAGE_COUNT + LATENCY_CYC;

  padc_top i_padc_top (.CLK_SYS_IN(clk_sys), .ARST_N_IN(arst_n),
    .STAGE0_CODE_IN(code[0]), .STAGE1_CODE_IN(code[1]), .STAGE2_CODE_IN(code[2]),
    .STAGE3_CODE_IN(code[3]), .SAMPLE_PHASE_OUT(smp_ph), .HOLD_PHASE_OUT(hld_ph),
    .STAGE_ODD_OUT(odd_ph), .OUT_WORD_OUT(word), .OUT_VALID_OUT(valid), .STALL_OUT(stall));
  padc_capture i_padc_capture (.clk_in(clk_sys), .word_in(word), .valid_in(valid),
    .stall_in(stall));

  // Clock of 4 ns period
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  // Count a comparison and report a mismatch
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // Expected corrected word of one sample, clamped to the output range
  function automatic logic [11:0] expw(input int k);
    int s;
    s = (int'(smp[k][0]) << 9) + (int'(smp[k][1]) << 6) + (int'(smp[k][2]) << 3)
      + int'(smp[k][3]) - 32'h444;
    if (s < 0) return 12'h000;
    if (s > 32'hFFF) return 12'hFFF;
    return s[11:0];
  endfunction

  // Print counts and the verdict, then stop
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Reset, at start or in mid-run, clears every output
  task automatic test_reset();
    @(negedge clk_sys);
    arst_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    check({smp_ph, hld_ph, odd_ph, valid, stall, word} === 17'h00000, "outputs in reset");
    arst_n = 1'b1;
    @(negedge clk_sys);
    // First edge after release enters the sample phase, all else still clear
    check({smp_ph, hld_ph, odd_ph, valid, stall, word} === 17'h10000, "outputs after release");
    $display("test reset done");
  endtask

  // Two phases never overlap, one in four each, hold two after sample
  task automatic test_phases();
    logic [15:0] s, h;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk_sys);
      s[i] = smp_ph;
      h[i] = hld_ph;
      check(!(smp_ph & hld_ph), "phases overlap");
      check(odd_ph === hld_ph, "odd stage clock not opposite");
    end
    check($countones(s) == 4 && $countones(h) == 4, "phase rate");
    for (int i = 2; i < 16; i++) begin
      check(h[i] === s[i-2], "hold not two after sample");
    end
    $display("test phases done");
  endtask

  // Stream n samples, stage j getting its code j cycles after stage zero
  task automatic test_stream(input int n, output int lat);
    int c0;
    for (int j = 0; j < 4; j++) code[j] = 4'h0;
    repeat (16) @(negedge clk_sys);
    c0 = i_padc_capture.cyc;
    for (int k = 0; k < n + 3; k++) begin
      for (int j = 0; j < 4; j++) begin
        code[j] = (k - j >= 0 && k - j < n) ? smp[k-j][j] : 4'h0;
      end
      @(negedge clk_sys);
    end
    repeat (20) @(negedge clk_sys);
    lat = -1;
    for (int t = c0; t < c0 + 24 && lat < 0; t++) begin
      if (i_padc_capture.word_log[t] === expw(0)) lat = t - c0;
    end
    check(lat == LAT_EXP, "first word latency");
    if (lat < 0) lat = 0;
    for (int k = 0; k < n; k++) begin
      check(i_padc_capture.word_log[c0+lat+k] === expw(k), "stream word");
      check(i_padc_capture.valid_log[c0+lat+k] === 1'b1, "valid dropped");
      check(i_padc_capture.stall_log[c0+lat+k] === 1'b0, "stall raised");
    end
    $display("test stream done, latency %0d", lat);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    for (int j = 0; j < 4; j++) code[j] = 4'h0;
    smp[0] = '{4'hF, 4'hF, 4'hF, 4'hF}; // Top code, all ones
    smp[1] = '{4'h0, 4'h0, 4'h0, 4'h0}; // Bottom code, all zeros
    smp[2] = '{4'h6, 4'h1, 4'h0, 4'h4}; // Midpoint, upper side
    smp[3] = '{4'h6, 4'h1, 4'h0, 4'h3}; // Midpoint, lower side
    smp[4] = '{4'h2, 4'h1, 4'h0, 4'h5}; // Lowest bit alone
    for (int k = 5; k < 64; k++) begin
      smp[k] = '{4'((k * 1) % 16), 4'((k * 3) % 16), 4'((k * 5) % 16), 4'((k * 7) % 16)};
    end
    test_reset();
    test_phases();
    test_stream(40, lat_a);
    test_reset();
    test_stream(20, lat_b);
    check(lat_a == lat_b, "latency not fixed");
    close_out();
  end

  // Watchdog against a hang
  initial begin
    #20000;
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    close_out();
  end
endmodule
